// [flash_ctl_map.svh]
// Register indices, field positions and reset values of the flash control block.
// Assumes a 32-bit classic Wishbone slave port with one aligned word per register.
`ifndef FLASH_CTL_MAP_SVH
`define FLASH_CTL_MAP_SVH
// Register word indices (byte address is four times the index)
`define REG_DIVIDER 3'h0
`define REG_OPTIONS 3'h1
`define REG_CONFIG 3'h2
`define REG_PROTECT 3'h3
`define REG_STATUS 3'h4
// Clock divider fields
`define DIV_LOADED_BIT 7
`define PRESCALE_BIT 6
`define DIV_FIELD_MSB 5
`define DIV_RESET 7'h00
`define PRESCALE_MAX 3'h7
// Options fields
`define BACKDOOR_KEY_ENABLE_BIT 7
`define NORED_BIT 6
`define SEC_MSB 1
`define SEC_UNSECURED 2'b10
`define OPT_IMPL_MASK 8'hc3
// Config and status fields
`define KEY_ACCESS_CONTROL_BIT 5
`define STAT_SECURE_BIT 0
`define STAT_ORDER_BAD_BIT 1
`define STAT_PE_BUSY_BIT 2
// Backdoor key window
`define KEY_BASE 13'h1ff6
`define KEY_BYTES 4'h8
`endif

// [flash_ctl_pkg.sv]
// Types shared by the flash control block and its clock divider.
// Constants live in flash_ctl_map.svh; this package holds only types.
package flash_ctl_pkg;
  typedef enum logic {st_load, st_run} boot_state_t;
  typedef enum logic [1:0] {pe_idle, pe_align, pe_pulse} pe_state_t;
endpackage : flash_ctl_pkg

// [flash_clk_div.sv]
// Internal flash clock generator: one-cycle tick per flash clock period.
// Assumes a single bus clock; the flash clock exists only as this enable.
`timescale 1ns/100ps
`include "flash_ctl_map.svh"
module flash_clk_div
  import flash_ctl_pkg::*;
#(
  parameter int DIV_W = 6
)
(
  input wire logic clk_i, // bus clock
  input wire logic rst_i, // synchronous reset, active high
  input wire logic run_i, // divider value valid
  input wire logic prescale_i, // divide input by eight first
  input wire logic [DIV_W-1:0] div_i, // divisor minus one
  output logic tick_o // one pulse per flash clock period
);
  logic [2:0] pre_cnt;
  logic [DIV_W-1:0] div_cnt;
  logic pre_en;

  assign pre_en = !prescale_i || (pre_cnt == `PRESCALE_MAX);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
      pre_cnt <= '0;
    else
      pre_cnt <= pre_cnt + 3'h1;
  end

  // Period is (div+1) selected-input cycles
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      div_cnt <= '0;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= pre_en && (div_cnt == div_i);
      if (pre_en)
        div_cnt <= (div_cnt == div_i) ? '0 : div_cnt + 1'b1;
    end
  end
endmodule : flash_clk_div

// [flash_ctl.sv]
// Flash clock divider, options and security control with a Wishbone slave.
// Assumes nonvolatile bytes are stable at reset and memory accesses are tagged
// by source; the command sequencer requests timing pulses through pe_start_i.
//
// Operation
// - Reset copies nonvolatile option and protection bytes
// - Divider bit 7 read-only; 6:0 write once
// - Reset clears loaded flag; first write sets
// - Program and erase refused until divider loaded
// - Prescale bit selects bus or bus/8
// - Flash clock is input divided by divisor+1
// - Timing pulse lasts pe_count_i whole flash periods, zero means one
// - Key enable gates in-order eight byte unlock
// - Debug writes never feed the key compare
// - Options bit 6 set disables vector redirection
// - Only security pattern 1:0 means unsecured
// - Secure state blocks unsecured sources from memory
// - Key match or blank check unsecures
// - Blocked write dropped, blocked read returns zero
// - Key access turns key writes into compares
// - Clearing key access triggers the comparison
//
// The implementer's own choices: the register offsets and the Wishbone register port.
`timescale 1ns/100ps
`include "flash_ctl_map.svh"
module flash_ctl
  import flash_ctl_pkg::*;
#(
  parameter int DIV_W = 6,
  parameter int PE_CNT_W = 8
)
(
  input wire logic clk_i, // bus clock, 100 MHz
  input wire logic rst_i, // synchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [7:0] nv_options_i, // nonvolatile_options_byte
  input wire logic [7:0] nv_protection_i, // nonvolatile_protection_byte
  input wire logic [63:0] nv_key_i, // backdoor_key_bytes, byte 0 in [7:0]
  input wire logic acc_req_i, // memory access request
  input wire logic acc_we_i, // access is a write
  input wire logic acc_trusted_i, // issued from secure memory
  input wire logic acc_debug_i, // issued by background_debug_commands
  input wire logic [15:0] acc_addr_i, // access address
  input wire logic [7:0] acc_rdata_i, // raw memory read data
  input wire logic [7:0] acc_wdata_i, // access write data
  output logic acc_grant_o, // access passed on to memory
  output logic acc_blocked_o, // access blocked by security
  output logic [7:0] acc_rdata_o, // filtered read data
  input wire logic blank_ok_i, // blank check passed, pulse
  input wire logic pe_start_i, // request program/erase pulses
  input wire logic [PE_CNT_W-1:0] pe_count_i, // pulse length in flash periods, zero means one
  output logic pe_pulse_o, // program/erase timing pulse
  output logic pe_done_o, // timing pulse ended, pulse
  output logic pe_refused_o, // request refused, pulse
  output logic internal_flash_clock_tick_o, // internal_flash_clock enable
  output logic divider_loaded_o, // divider_loaded_flag
  output logic secure_o, // memory secured
  output logic redirect_en_o, // vector redirection enabled
  output logic [7:0] protection_o // working_protection_register
);
  boot_state_t boot;
  pe_state_t pe_state;
  logic divider_loaded_flag;
  logic prescale_by_eight;
  logic [DIV_W-1:0] divisor;
  logic backdoor_key_enable;
  logic vector_redirect_disable;
  logic [1:0] security_state_field;
  logic key_access_control;
  logic [63:0] key_buf;
  logic [3:0] key_idx;
  logic key_order_bad;
  logic [PE_CNT_W-1:0] pe_left;
  logic wb_req, wb_wr, reg_wr, is_secure, blocked, in_key, key_sink, unlock;
  logic [7:0] reg_rd;
  logic tick;

  ////////////////////////////////////////////////////////////////////////
  // Reset-time copy of the nonvolatile bytes

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      boot <= st_load;
    else
      boot <= st_run;
  end

  // Copied in the first cycle after release so reset itself takes constants
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      backdoor_key_enable <= 1'b0;
      vector_redirect_disable <= 1'b1;
      protection_o <= 8'hff;
    end
    else if (boot == st_load)
    begin
      backdoor_key_enable <= nv_options_i[`BACKDOOR_KEY_ENABLE_BIT];
      vector_redirect_disable <= nv_options_i[`NORED_BIT];
      protection_o <= nv_protection_i;
    end
  end

  // Only reset load, key unlock and blank check events touch the security field
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      security_state_field <= 2'b11;
    else if (boot == st_load)
      security_state_field <= nv_options_i[`SEC_MSB:0];
    else if (unlock || blank_ok_i)
      security_state_field <= `SEC_UNSECURED;
  end

  assign is_secure = security_state_field != `SEC_UNSECURED;

  ////////////////////////////////////////////////////////////////////////
  // Wishbone slave

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o && boot == st_run;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];

  function automatic logic hits(input logic [2:0] idx, input logic [7:0] adr);
    hits = adr == {3'h0, idx, 2'h0};
  endfunction : hits

  always_comb
  begin
    reg_rd = 8'h00;
    if (hits(`REG_DIVIDER, wb_adr_i))
      reg_rd = {divider_loaded_flag, prescale_by_eight, divisor};
    else if (hits(`REG_OPTIONS, wb_adr_i))
      reg_rd = {backdoor_key_enable, vector_redirect_disable, 4'h0,
                security_state_field} & `OPT_IMPL_MASK;
    else if (hits(`REG_CONFIG, wb_adr_i))
      reg_rd = 8'(key_access_control) << `KEY_ACCESS_CONTROL_BIT;
    else if (hits(`REG_PROTECT, wb_adr_i))
      reg_rd = protection_o;
    else if (hits(`REG_STATUS, wb_adr_i))
      reg_rd = {5'h00, pe_state != pe_idle, key_order_bad, is_secure};
  end

  // One wait state; unmapped addresses ack with zero and ignore writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req && !wb_we_i ? {24'h00_0000, reg_rd} : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock divider register

  assign reg_wr = wb_wr && hits(`REG_DIVIDER, wb_adr_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      divider_loaded_flag <= 1'b0;
      prescale_by_eight <= 1'b0;
      divisor <= DIV_W'(`DIV_RESET);
    end
    else if (reg_wr)
    begin
      divider_loaded_flag <= 1'b1;
      if (!divider_loaded_flag)
      begin
        prescale_by_eight <= wb_dat_i[`PRESCALE_BIT];
        divisor <= wb_dat_i[DIV_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      divider_loaded_o <= 1'b0;
      secure_o <= 1'b1;
      redirect_en_o <= 1'b0;
    end
    else
    begin
      divider_loaded_o <= divider_loaded_flag;
      secure_o <= is_secure;
      redirect_en_o <= !vector_redirect_disable;
    end
  end

  flash_clk_div #(.DIV_W(DIV_W)) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(divider_loaded_flag),
    .prescale_i(prescale_by_eight),
    .div_i(divisor),
    .tick_o(tick)
  );

  assign internal_flash_clock_tick_o = tick;

  ////////////////////////////////////////////////////////////////////////
  // Program/erase timing pulses, aligned to flash clock ticks

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pe_state <= pe_idle;
      pe_left <= '0;
      pe_pulse_o <= 1'b0;
      pe_done_o <= 1'b0;
      pe_refused_o <= 1'b0;
    end
    else
    begin
      pe_done_o <= 1'b0;
      pe_refused_o <= 1'b0;
      unique case (pe_state)
        pe_idle:
          if (pe_start_i)
          begin
            if (!divider_loaded_flag)
              pe_refused_o <= 1'b1;
            else
            begin
              pe_state <= pe_align;
              pe_left <= (pe_count_i == '0) ? PE_CNT_W'(1) : pe_count_i;
            end
          end
        pe_align:
          if (tick)
          begin
            pe_state <= pe_pulse;
            pe_pulse_o <= 1'b1;
          end
        pe_pulse:
          if (tick)
          begin
            pe_left <= pe_left - 1'b1;
            if (pe_left == PE_CNT_W'(1))
            begin
              pe_state <= pe_idle;
              pe_pulse_o <= 1'b0;
              pe_done_o <= 1'b1;
            end
          end
        default:
          pe_state <= pe_idle;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Backdoor key entry and comparison

  assign in_key = acc_addr_i[15:3] == `KEY_BASE;
  // Debug-sourced writes are never taken as key bytes
  assign key_sink = acc_req_i && acc_we_i && in_key && key_access_control
                    && acc_trusted_i && !acc_debug_i;
  assign unlock = wb_wr && hits(`REG_CONFIG, wb_adr_i) && key_access_control
                  && !wb_dat_i[`KEY_ACCESS_CONTROL_BIT] && backdoor_key_enable
                  && key_idx == `KEY_BYTES && !key_order_bad
                  && key_buf == nv_key_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      key_access_control <= 1'b0;
    else if (wb_wr && hits(`REG_CONFIG, wb_adr_i))
      key_access_control <= wb_dat_i[`KEY_ACCESS_CONTROL_BIT];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      key_buf <= 64'h0;
      key_idx <= 4'h0;
      key_order_bad <= 1'b0;
    end
    else if (!key_access_control)
    begin
      key_idx <= 4'h0;
      if (wb_wr && hits(`REG_CONFIG, wb_adr_i) && wb_dat_i[`KEY_ACCESS_CONTROL_BIT])
        key_order_bad <= 1'b0;
    end
    else if (key_sink)
    begin
      // Bytes must arrive strictly in address order
      if (key_idx != `KEY_BYTES && acc_addr_i[2:0] == key_idx[2:0])
      begin
        key_buf[{key_idx[2:0], 3'h0} +: 8] <= acc_wdata_i;
        key_idx <= key_idx + 4'h1;
      end
      else
        key_order_bad <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Memory access filter

  assign blocked = acc_req_i && is_secure && (!acc_trusted_i || acc_debug_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      acc_grant_o <= 1'b0;
      acc_blocked_o <= 1'b0;
      acc_rdata_o <= 8'h00;
    end
    else
    begin
      acc_grant_o <= acc_req_i && !blocked && !key_sink;
      acc_blocked_o <= blocked;
      acc_rdata_o <= (acc_req_i && !blocked && !acc_we_i) ? acc_rdata_i : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  div_write_once_a: assert property (
    reg_wr && divider_loaded_flag |=> $stable({prescale_by_eight, divisor}))
    else $error("divider changed after first write");

  flag_first_write_a: assert property (
    reg_wr |=> divider_loaded_flag ##1 divider_loaded_o)
    else $error("loaded flag not set by write");

  refuse_unloaded_a: assert property (
    pe_start_i && pe_state == pe_idle && !divider_loaded_flag |=> pe_refused_o && !pe_pulse_o)
    else $error("program/erase not refused before divider load");

  pulse_on_tick_a: assert property (
    $rose(pe_pulse_o) || $fell(pe_pulse_o) |-> $past(tick))
    else $error("pulse edge off the flash clock");

  options_hold_a: assert property (
    boot == st_run && $past(boot == st_run)
    |-> $stable({backdoor_key_enable, vector_redirect_disable}))
    else $error("options changed without reset");

  unsecure_event_a: assert property (
    blank_ok_i |=> !is_secure ##1 !secure_o)
    else $error("blank check did not unsecure");

  blocked_read_a: assert property (
    blocked |=> acc_rdata_o == 8'h00 && !acc_grant_o && acc_blocked_o)
    else $error("blocked access leaked");

  debug_key_a: assert property (
    acc_req_i && acc_debug_i && key_access_control |=> $stable(key_buf))
    else $error("debug write reached the key buffer");

  key_disabled_a: assert property (
    boot == st_run && !backdoor_key_enable && !blank_ok_i |=> $stable(security_state_field))
    else $error("unlock while key disabled");

  ack_single_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  unlock_c: cover property (unlock);
  pulse_run_c: cover property (pe_start_i && divider_loaded_flag ##[1:1000] pe_done_o);
  blocked_c: cover property (blocked && acc_debug_i);
  refused_c: cover property (pe_refused_o);
endmodule : flash_ctl

// [tb_top.sv]
// Self-checking bench for the flash control block: registers over Wishbone,
// access filter, key unlock, blank check and program/erase timing pulses.
// Assumes the 100 MHz bus clock and the register map of flash_ctl_map.svh.
`timescale 1ns/100ps
`include "flash_ctl_map.svh"
module tb_top
  import flash_ctl_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [7:0] nv_options_i = 8'h82;
  logic [7:0] nv_protection_i = 8'hf8;
  logic [63:0] nv_key_i = 64'h0123456789abcdef;
  logic acc_req_i = 1'b0;
  logic acc_we_i = 1'b0;
  logic acc_trusted_i = 1'b0;
  logic acc_debug_i = 1'b0;
  logic [15:0] acc_addr_i = 16'h0000;
  logic [7:0] acc_rdata_i = 8'h00;
  logic [7:0] acc_wdata_i = 8'h00;
  logic [7:0] acc_rdata_o;
  logic [7:0] protection_o;
  logic acc_grant_o, acc_blocked_o, pe_pulse_o, pe_done_o, pe_refused_o, internal_flash_clock_tick_o;
  logic divider_loaded_o, secure_o, redirect_en_o;
  logic blank_ok_i = 1'b0;
  logic pe_start_i = 1'b0;
  logic [7:0] pe_count_i = 8'h00;
  int bad_count = 0;
  int checked = 0;
  int n;
  logic [31:0] rd;
  logic [7:0] o;
  logic refused;

  flash_ctl dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .nv_options_i, .nv_protection_i, .nv_key_i,
    .acc_req_i, .acc_we_i, .acc_trusted_i, .acc_debug_i, .acc_addr_i, .acc_rdata_i,
    .acc_wdata_i,
    .acc_grant_o, .acc_blocked_o, .acc_rdata_o, .blank_ok_i, .pe_start_i, .pe_count_i,
    .pe_pulse_o, .pe_done_o, .pe_refused_o, .internal_flash_clock_tick_o, .divider_loaded_o, .secure_o,
    .redirect_en_o, .protection_o);

  always #5 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic do_reset(input logic [7:0] opt);
    @(posedge clk_i);
    nv_options_i <= opt;
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : do_reset

  // Classic single cycle; ack is sampled at the edge, so the old value is seen there
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] q);
    int w;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hf;
    w = 0;
    do
    begin
      @(posedge clk_i);
      w++;
    end
    while (wb_ack_o !== 1'b1 && w < 100);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (w >= 100)
      check("wb_ack", 32'h1, 32'h0);
  endtask : wb

  task automatic acc(input logic we, input logic tr, input logic dbg,
                     input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    acc_req_i <= 1'b1;
    acc_we_i <= we;
    acc_trusted_i <= tr;
    acc_debug_i <= dbg;
    acc_addr_i <= a;
    acc_rdata_i <= d;
    acc_wdata_i <= d;
    @(posedge clk_i);
    acc_req_i <= 1'b0;
    #1;
  endtask : acc

  // Bus cycles from one flash clock tick to the next
  task automatic tick_gap(output int gap);
    int t;
    t = 0;
    gap = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      t++;
    end
    while (internal_flash_clock_tick_o !== 1'b1 && t < 2000);
    do
    begin
      @(posedge clk_i);
      #1;
      gap++;
    end
    while (internal_flash_clock_tick_o !== 1'b1 && gap < 2000);
  endtask : tick_gap

  // Length counts bus cycles with the timing pulse high, up to the done strobe
  task automatic pulse(input logic [7:0] cnt, output int len, output logic rf);
    @(posedge clk_i);
    pe_start_i <= 1'b1;
    pe_count_i <= cnt;
    @(posedge clk_i);
    pe_start_i <= 1'b0;
    #1;
    rf = pe_refused_o;
    len = 0;
    if (rf === 1'b1)
      return;
    for (int i = 0; i < 2000; i++)
    begin
      @(posedge clk_i);
      #1;
      if (pe_pulse_o === 1'b1)
        len++;
      if (pe_done_o === 1'b1)
        break;
    end
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    results();
  end

  initial
  begin
    for (int s = 0; s < 4; s++)
    begin
      o = {s[1], s[0], 4'hf, s[1], s[0]};
      do_reset(o);
      wb(1'b0, 8'h04, 32'h0, rd);
      check("options", {24'h0, o & 8'hc3}, rd);
      check("secure", s != 2, secure_o);
      check("redirect", !o[6], redirect_en_o);
      check("protection", 8'hf8, protection_o);
    end
    wb(1'b1, 8'h04, 32'h0, rd);
    wb(1'b0, 8'h04, 32'h0, rd);
    check("options_ro", 32'hc3, rd);
    // Secure, key enabled: untrusted, debug, trusted reads in turn
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b0, i > 0, i == 1, 16'h1000, 8'h5a);
      check("blocked", i < 2, acc_blocked_o);
      check("grant", i == 2, acc_grant_o);
      check("acc_rdata", (i == 2) ? 8'h5a : 8'h00, acc_rdata_o);
    end
    pulse(8'h01, n, refused);
    check("refused", 1'b1, refused);
    wb(1'b0, 8'h00, 32'h0, rd);
    check("divider_rst", 32'h0, rd);
    // The fast setting only times the flash clock; pulses need the in-range one
    for (int k = 0; k < 2; k++)
    begin
      do_reset(8'h82);
      wb(1'b1, 8'h00, k ? 32'h7f : 32'h01, rd);
      wb(1'b1, 8'h00, k ? 32'h00 : 32'h7f, rd);
      wb(1'b0, 8'h00, 32'h0, rd);
      check("divider", k ? 32'hff : 32'h81, rd);
      check("loaded", 1'b1, divider_loaded_o);
      tick_gap(n);
      check("internal_flash_clock_period", k ? 512 : 2, n);
    end
    // Eight times 64 bus cycles gives about 195 kHz at 100 MHz
    pulse(8'h00, n, refused);
    check("refused_after", 1'b0, refused);
    check("pulse_one", 512, n);
    pulse(8'h02, n, refused);
    check("pulse_two", 1024, n);
    for (int c = 0; c < 3; c++)
    begin
      do_reset(c == 1 ? 8'h03 : 8'h83);
      wb(1'b1, 8'h08, 32'h20, rd);
      for (int b = 0; b < 8; b++)
      begin
        acc(1'b1, 1'b1, c == 2, 16'hffb0 + 16'(b), nv_key_i[8*b +: 8]);
        if (c == 0)
          check("key_grant", 1'b0, acc_grant_o);
      end
      wb(1'b1, 8'h08, 32'h0, rd);
      repeat (3) @(posedge clk_i);
      #1;
      check("key_secure", c != 0, secure_o);
    end
    do_reset(8'h83);
    wb(1'b1, 8'h08, 32'h20, rd);
    for (int b = 0; b < 8; b++)
      acc(1'b1, 1'b1, 1'b0, 16'hffb0 + 16'(b), nv_key_i[8*b +: 8]);
    wb(1'b1, 8'h08, 32'h0, rd);
    repeat (3) @(posedge clk_i);
    wb(1'b0, 8'h04, 32'h0, rd);
    check("key_sec_field", 32'h82, rd);
    do_reset(8'h03);
    @(posedge clk_i);
    blank_ok_i <= 1'b1;
    @(posedge clk_i);
    blank_ok_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check("blank_secure", 1'b0, secure_o);
    acc(1'b0, 1'b0, 1'b1, 16'h0100, 8'h3c);
    check("open_rdata", 8'h3c, acc_rdata_o);
    results();
  end
endmodule : tb_top
